// File: verilog/eeprom_map.svh
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------
// bus identity and memory geometry
// ----------------------------------------
`define EE_DEV_ADDR 7'h50
`define EE_ADDR_W 14
`define EE_DEPTH 16384
`define EE_PAGE_BITS 6
`define EE_HI_BITS 6
`define EE_BIT_LAST 4'h7
`define EE_BIT_FULL 4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define EE_CLK_PERIOD_NS 4
`define EE_PROG_TIME_US 6000
`define EE_PROG_CYCLES ((`EE_PROG_TIME_US * 1000) / `EE_CLK_PERIOD_NS)

`endif

// File: verilog/eeprom_pkg.sv
`default_nettype none

package eeprom_pkg;

    // bus engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_MACK = 3'b100
    } state_t;

    // meaning of the byte being received
    typedef enum logic [1:0] {
        K_DEV  = 2'b00,
        K_HI   = 2'b01,
        K_LO   = 2'b10,
        K_DATA = 2'b11
    } kind_t;

endpackage

`default_nettype wire

// File: verilog/eeprom_array.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module eeprom_array (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [`EE_ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    // read port
    input wire logic [`EE_ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:`EE_DEPTH-1];

    // one write and one registered read per cycle
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

`default_nettype wire

// File: verilog/i2c_eeprom_access_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_map.svh"

module i2c_eeprom_access_engine #(
    parameter int unsigned PROG_CYCLES = `EE_PROG_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // status
    output logic prog_busy
);

    // ----------------------------------------
    // pin synchronisers and edge finders
    // ----------------------------------------
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

    // two flops per pin, then one delay for edges
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // ----------------------------------------
    // engine state
    // ----------------------------------------
    eeprom_pkg::state_t state;
    eeprom_pkg::kind_t kind;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic macked;
    logic data_seen;
    logic [`EE_HI_BITS-1:0] addr_hi;
    logic [`EE_ADDR_W-1:0] ptr;
    logic mem_we;
    logic [`EE_ADDR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [31:0] timer;

    // decoded events
    wire byte_done = (state == eeprom_pkg::ST_RX) && scl_fall && (cnt == `EE_BIT_FULL);
    wire dev_hit = (shreg[7:1] == `EE_DEV_ADDR);
    wire wr_evt = byte_done && (kind == eeprom_pkg::K_DATA);
    wire load_evt = scl_fall && ((state == eeprom_pkg::ST_ACK && rw) ||
                                 (state == eeprom_pkg::ST_MACK && macked));
    wire launch = stop_det && !prog_busy && data_seen;
    wire [`EE_ADDR_W-1:0] page_next = {ptr[`EE_ADDR_W-1:`EE_PAGE_BITS],
                                       ptr[`EE_PAGE_BITS-1:0] + 6'h01};
    wire [`EE_ADDR_W-1:0] ptr_inc = ptr + 14'h0001;

    // ----------------------------------------
    // bus engine
    // ----------------------------------------
    // main byte sequencer; busy wins over every bus event
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= eeprom_pkg::ST_IDLE;
            kind <= eeprom_pkg::K_DEV;
            cnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            macked <= 1'b0;
            data_seen <= 1'b0;
            addr_hi <= 6'h00;
            ptr <= 14'h0000;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            mem_we <= 1'b0;
            mem_waddr <= 14'h0000;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            if (prog_busy) begin
                state <= eeprom_pkg::ST_IDLE;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                state <= eeprom_pkg::ST_RX;
                kind <= eeprom_pkg::K_DEV;
                cnt <= 4'h0;
                sda_oe <= 1'b0;
                data_seen <= 1'b0;
            end else if (stop_det) begin
                state <= eeprom_pkg::ST_IDLE;
                sda_oe <= 1'b0;
                data_seen <= 1'b0;
            end else begin
                case (state)
                    eeprom_pkg::ST_RX: begin
                        if (scl_rise && cnt != `EE_BIT_FULL) begin
                            shreg <= {shreg[6:0], sda_s};
                            cnt <= cnt + 4'h1;
                        end else if (byte_done) begin
                            state <= eeprom_pkg::ST_ACK;
                            sda_oe <= 1'b1;
                            cnt <= 4'h0;
                            case (kind)
                                eeprom_pkg::K_DEV: begin
                                    rw <= shreg[0];
                                    kind <= eeprom_pkg::K_HI;
                                    if (!dev_hit) begin
                                        state <= eeprom_pkg::ST_IDLE;
                                        sda_oe <= 1'b0;
                                    end
                                end
                                eeprom_pkg::K_HI: begin
                                    addr_hi <= shreg[`EE_HI_BITS-1:0];
                                    kind <= eeprom_pkg::K_LO;
                                end
                                eeprom_pkg::K_LO: begin
                                    ptr <= {addr_hi, shreg};
                                    kind <= eeprom_pkg::K_DATA;
                                end
                                default: begin
                                    mem_we <= 1'b1;
                                    mem_waddr <= ptr;
                                    mem_wdata <= shreg;
                                    ptr <= page_next;
                                    data_seen <= 1'b1;
                                end
                            endcase
                        end
                    end
                    eeprom_pkg::ST_ACK: begin
                        if (load_evt) begin
                            shreg <= mem_rdata;
                            sda_oe <= ~mem_rdata[7];
                            ptr <= ptr_inc;
                            cnt <= 4'h0;
                            state <= eeprom_pkg::ST_TX;
                        end else if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state <= eeprom_pkg::ST_RX;
                        end
                    end
                    eeprom_pkg::ST_TX: begin
                        if (scl_fall) begin
                            if (cnt == `EE_BIT_LAST) begin
                                sda_oe <= 1'b0;
                                state <= eeprom_pkg::ST_MACK;
                            end else begin
                                shreg <= {shreg[6:0], 1'b0};
                                sda_oe <= ~shreg[6];
                                cnt <= cnt + 4'h1;
                            end
                        end
                    end
                    eeprom_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            macked <= ~sda_s;
                        end else if (load_evt) begin
                            shreg <= mem_rdata;
                            sda_oe <= ~mem_rdata[7];
                            ptr <= ptr_inc;
                            cnt <= 4'h0;
                            state <= eeprom_pkg::ST_TX;
                        end else if (scl_fall) begin
                            state <= eeprom_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state <= eeprom_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // programming timer
    // ----------------------------------------
    // STOP after written data starts the self-timed lockout
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prog_busy <= 1'b0;
            timer <= 32'h0000_0000;
        end else if (launch) begin
            prog_busy <= 1'b1;
            timer <= PROG_CYCLES - 32'h1;
        end else if (prog_busy) begin
            if (timer == 32'h0000_0000) begin
                prog_busy <= 1'b0;
            end else begin
                timer <= timer - 32'h1;
            end
        end
    end

    // ----------------------------------------
    // memory array
    // ----------------------------------------
    eeprom_array u_array (
        .clk(ref_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(ptr),
        .rdata(mem_rdata)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    busy_silent_a: assert property (prog_busy |-> !sda_oe)
        else $error("bus driven during programming");
    busy_nack_a: assert property (prog_busy && start_det |=> state == eeprom_pkg::ST_IDLE)
        else $error("start taken while busy");
    addr_match_a: assert property ($rose(sda_oe) && state == eeprom_pkg::ST_ACK &&
                                   kind == eeprom_pkg::K_HI |-> $past(dev_hit))
        else $error("foreign address acknowledged");
    data_ack_a: assert property (wr_evt && !prog_busy && !start_det && !stop_det
                                 |=> sda_oe && mem_we)
        else $error("data byte not acknowledged");
    page_wrap_a: assert property (mem_we |-> ptr[13:6] == mem_waddr[13:6] &&
                                  ptr[5:0] == mem_waddr[5:0] + 6'h01)
        else $error("page address advanced wrongly");
    stop_prog_a: assert property (launch |=> prog_busy ##1 prog_busy)
        else $error("stop did not start programming");
    prog_end_a: assert property (prog_busy && timer == 32'h0 |=> !prog_busy)
        else $error("programming did not end on time");
    read_inc_a: assert property (load_evt && !prog_busy && !start_det && !stop_det
                                 |=> ptr == $past(ptr) + 14'h0001)
        else $error("read pointer not advanced");
    nack_end_a: assert property (state == eeprom_pkg::ST_MACK && scl_fall && !macked &&
                                 !start_det && !stop_det |=> state == eeprom_pkg::ST_IDLE)
        else $error("read continued after nack");

    prog_seen_c: cover property (launch);
    seq_read_c: cover property (state == eeprom_pkg::ST_MACK && load_evt);
    wrap_c: cover property (load_evt && ptr == 14'h3fff);

endmodule

`default_nettype wire

// File: verif/bus_master.sv
`timescale 1ns/1ps
`default_nettype none

module bus_master (
    // clock
    input wire logic ref_clk,
    // bus pins
    output logic scl,
    output logic sda_rel,
    input wire logic sda
);
    // ----------------------------------------
    // bus primitives on the falling edge
    // ----------------------------------------
    // idle bus: both lines released, clock stands still
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    // wait block clock cycles
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // one bit: low 8 cycles with data set mid-way, high 4 cycles
    task automatic bit_xfer(input logic b, output logic s);
        tick(4);
        sda_rel = b;
        tick(4);
        scl = 1'b1;
        tick(3);
        s = sda;
        tick(1);
        scl = 1'b0;
    endtask

    // start, or repeated start from a low clock
    task automatic start();
        if (scl === 1'b0) begin
            tick(4);
            sda_rel = 1'b1;
            tick(4);
            scl = 1'b1;
        end
        tick(4);
        sda_rel = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask

    // a stop closes the frame, then the bus rests 8 cycles
    task automatic stop();
        tick(4);
        sda_rel = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_rel = 1'b1;
        tick(8);
    endtask

    // byte out msb first, ninth clock samples the acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    // byte in msb first; mack high answers with an acknowledge
    task automatic rd_byte(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(~mack, s);
    endtask
endmodule

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ----------------------------------------
    // bench, design and bus wiring
    // ----------------------------------------
    localparam int unsigned prog = 400;
    localparam logic [7:0] bad_ids [3] = '{8'ha2, 8'h20, 8'hb1};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    wire scl, sda_rel, sda_in, sda_out, sda_oe, prog_busy;
    int err_total = 0;
    int samples_checked = 0;
    logic ack;
    logic [7:0] rd;

    // released line floats high through the pull-up
    assign sda_in = sda_oe ? (sda_out & sda_rel) : sda_rel;

    i2c_eeprom_access_engine #(.PROG_CYCLES(prog)) i_i2c_eeprom_access_engine (
        .ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .prog_busy(prog_busy));
    bus_master i_bus_master (.ref_clk(ref_clk), .scl(scl), .sda_rel(sda_rel), .sda(sda_in));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // row 0x0c40 after 66 bytes written from offset 0x3e
    function automatic logic [7:0] row_val(input int j);
        int k;
        k = (j + 2) % 64;
        if (j >= 62) k = k + 64;
        return 8'(k) + 8'h11;
    endfunction

    // address phase of a write frame
    task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha0, ack);
        check(ack === 1'b1, "device id not acknowledged");
        i_bus_master.wr_byte(hi, ack);
        check(ack === 1'b1, "high address not acknowledged");
        i_bus_master.wr_byte(lo, ack);
        check(ack === 1'b1, "low address not acknowledged");
    endtask

    // write n bytes of value base+k, then stop
    task automatic write_run(input logic [7:0] hi, lo, input int n, input logic [7:0] base);
        set_addr(hi, lo);
        for (int k = 0; k < n; k++) begin
            i_bus_master.wr_byte(8'(k) + base, ack);
            check(ack === 1'b1, "data byte not acknowledged");
        end
        i_bus_master.stop();
    endtask

    // lockout while programming, answer again once done
    task automatic wait_ready();
        int n;
        repeat (6) @(negedge ref_clk);
        check(prog_busy === 1'b1, "programming did not start");
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha0, ack);
        check(ack === 1'b0, "acknowledged while programming");
        i_bus_master.stop();
        n = 0;
        while (prog_busy !== 1'b0 && n < prog + 50) begin
            @(negedge ref_clk);
            n++;
        end
        check(n >= prog - 160 && n <= prog - 135, "programming time off");
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha0, ack);
        check(ack === 1'b1, "no acknowledge after programming");
        i_bus_master.stop();
    endtask

    // foreign ids: no answer, following bytes store nothing
    task automatic t_addr_filter();
        foreach (bad_ids[i]) begin
            i_bus_master.start();
            i_bus_master.wr_byte(bad_ids[i], ack);
            check(ack === 1'b0, "foreign id acknowledged");
            i_bus_master.wr_byte(8'h00, ack);
            i_bus_master.wr_byte(8'h55, ack);
            i_bus_master.wr_byte(8'h66, ack);
            i_bus_master.stop();
            check(prog_busy === 1'b0, "foreign frame programmed");
        end
    endtask

    // 66 bytes from 0x0c7e, top address bits set but ignored
    task automatic t_page_write();
        write_run(8'hcc, 8'h7e, 66, 8'h11);
        wait_ready();
    endtask

    // random then sequential read of the row, then current-address read
    task automatic t_reads();
        set_addr(8'h0c, 8'h40);
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha1, ack);
        check(ack === 1'b1, "read id not acknowledged");
        for (int j = 0; j < 63; j++) begin
            i_bus_master.rd_byte(j < 62, rd);
            check(rd === row_val(j), "row byte wrong");
        end
        i_bus_master.stop();
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha1, ack);
        check(ack === 1'b1, "current read not acknowledged");
        i_bus_master.rd_byte(1'b0, rd);
        check(rd === row_val(63), "current read byte wrong");
        i_bus_master.stop();
    endtask

    // sequential read runs over the top of the array to 0x0000
    task automatic t_top_wrap();
        write_run(8'h3f, 8'hff, 1, 8'h77);
        wait_ready();
        write_run(8'h00, 8'h00, 1, 8'h98);
        wait_ready();
        set_addr(8'h3f, 8'hff);
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha1, ack);
        check(ack === 1'b1, "wrap read id not acknowledged");
        i_bus_master.rd_byte(1'b1, rd);
        check(rd === 8'h77, "top byte wrong");
        i_bus_master.rd_byte(1'b0, rd);
        check(rd === 8'h98, "no wrap to zero");
        i_bus_master.stop();
    endtask

    // reset in mid-programming ends the lockout and puts the pointer at 0x0000
    task automatic t_mid_reset();
        write_run(8'h00, 8'h01, 1, 8'h5a);
        repeat (4) @(negedge ref_clk);
        check(prog_busy === 1'b1, "lockout did not start");
        resetn = 1'b0;
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check(sda_oe === 1'b0 && prog_busy === 1'b0, "outputs not idle after mid reset");
        i_bus_master.start();
        i_bus_master.wr_byte(8'ha1, ack);
        check(ack === 1'b1, "no acknowledge after mid reset");
        i_bus_master.rd_byte(1'b1, rd);
        check(rd === 8'h98, "pointer not at zero after reset");
        i_bus_master.rd_byte(1'b0, rd);
        check(rd === 8'h5a, "byte written before reset lost");
        i_bus_master.stop();
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog against a hung bus
    initial begin
        #300000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    // main sequence
    initial begin
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check(sda_oe === 1'b0 && prog_busy === 1'b0, "outputs not idle after reset");
        t_addr_filter();
        t_page_write();
        t_reads();
        t_top_wrap();
        t_mid_reset();
        conclude();
    end
endmodule

`default_nettype wire
